// ---- msc_pkg.sv ----
// Constants, rate tables and mode codes shared by the modem sample clock logic
`default_nettype none
package msc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Master clock and accumulator
    localparam longint unsigned CLK_HZ    = 250_000_000;
    localparam int              ACC_W     = 32;

    typedef logic [ACC_W-1:0] msc_inc_t;
    typedef msc_inc_t         msc_tab_t [8];
    typedef int unsigned      msc_hz_t  [8];

    ////////////////////////////////////////////////////////////////////////////
    // Operating mode field codes
    localparam logic [2:0] MODE_ASYNC       = 3'h0;
    localparam logic [2:0] MODE_ASYNC_TERMINAL_SYNC_INPUT = 3'h7;
    localparam logic [2:0] MODE_V32_TERMINAL_SYNC_INPUT   = 3'h4;
    localparam logic [2:0] MODE_V32_INT     = 3'h5;
    localparam logic [2:0] MODE_V32_LOOP    = 3'h6;
    localparam logic [2:0] MODE_RESET       = MODE_ASYNC;

    ////////////////////////////////////////////////////////////////////////////
    // Rate tables in Hz, indexed by the 3-bit (or zero-extended 2-bit) fields
    localparam msc_hz_t CONV_HZ = '{7200, 8000, 9600, 9600, 9600, 9600, 9600, 9600};
    localparam msc_hz_t BIT_HZ  = '{1200, 2400, 4800, 7200, 9600, 12000, 14400, 19200};
    localparam msc_hz_t SYM_HZ  = '{300, 600, 1200, 1600, 2400, 3000, 3200, 4800};
    localparam msc_hz_t SYNC_HZ = '{4800, 7200, 9600, 14400, 19200, 19200, 19200, 19200};
    localparam logic [2:0] BIT_SEL_FIXED = 3'h7;   // Bit rate exempt from 8/7 scaling

    // Phase increment per master clock, optionally scaled by 8/7
    function automatic msc_tab_t msc_tab(input msc_hz_t hz, input bit scaled);
        msc_tab_t        t;
        longint unsigned n;
        for (int i = 0; i < 8; i++)
        begin
            n    = ((longint'(hz[i]) << ACC_W) * (scaled ? 64'd8 : 64'd7)) / (64'd7 * CLK_HZ);
            t[i] = n[ACC_W-1:0];
        end
        return t;
    endfunction

    localparam msc_tab_t CONV_INC   = msc_tab(CONV_HZ, 1'b0);
    localparam msc_tab_t CONV_INC_X = msc_tab(CONV_HZ, 1'b1);
    localparam msc_tab_t BIT_INC    = msc_tab(BIT_HZ, 1'b0);
    localparam msc_tab_t BIT_INC_X  = msc_tab(BIT_HZ, 1'b1);
    localparam msc_tab_t SYM_INC    = msc_tab(SYM_HZ, 1'b0);
    localparam msc_tab_t SYM_INC_X  = msc_tab(SYM_HZ, 1'b1);
    localparam msc_tab_t SYNC_INC   = msc_tab(SYNC_HZ, 1'b0);
    localparam msc_tab_t SYNC_INC_X = msc_tab(SYNC_HZ, 1'b1);

    ////////////////////////////////////////////////////////////////////////////
    // Phase adjustment and timing
    localparam int             PH_W          = 9;
    localparam int             STEP_W        = 14;
    localparam logic [PH_W-1:0] PH_EXT_MAX   = 9'h0c0;   // +192
    localparam int             PH_UNIT_CYC   = 16;       // Master clocks per adjust unit
    localparam int             SOFT_RESET_NS = 100;
    localparam int             SOFT_RESET_CYC_I = (SOFT_RESET_NS * 250 + 999) / 1000;
    localparam logic [7:0]     SOFT_RESET_CYC = 8'(SOFT_RESET_CYC_I);
    localparam int             DPLL_DEAD_W   = 24;       // Error below 2**24 counts as locked

endpackage
`default_nettype wire

// ---- msc_nco.sv ----
// Phase accumulator that makes one strobe pulse and one square clock
`timescale 1ns/1ns
`default_nettype none
module msc_nco
    import msc_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_resetn,
    input  wire logic     i_ce,
    input  wire logic     i_restart,
    input  wire logic     i_hold,
    input  wire logic     i_extra,
    input  wire msc_inc_t i_inc,
    output logic          o_pulse,
    output logic          o_level,
    output msc_inc_t      o_acc
);

    msc_inc_t         acc;
    logic             pulse;
    msc_inc_t         next_acc;
    logic             next_pulse;
    logic [ACC_W:0]   sum;

    ////////////////////////////////////////////////////////////////////////////
    // Hold retards by one cycle, extra advances by one; both keep the rate
    always_comb
    begin
        sum        = {1'b0, acc} + {1'b0, i_inc};
        if (i_extra)
            sum    = sum + {1'b0, i_inc};
        next_acc   = sum[ACC_W-1:0];
        next_pulse = sum[ACC_W];
        if (i_hold)
        begin
            next_acc   = acc;
            next_pulse = 1'b0;
        end
        if (i_restart)
        begin
            next_acc   = '0;
            next_pulse = 1'b1;     // Restart is itself a strobe so groups align
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            acc   <= '0;
            pulse <= 1'b0;
        end
        else if (i_ce)
        begin
            acc   <= next_acc;
            pulse <= next_pulse;
        end
    end

    assign o_pulse = pulse;
    assign o_level = acc[ACC_W-1];
    assign o_acc   = acc;

endmodule
`default_nettype wire

// ---- msc_dpll.sv ----
// Digital phase-locked loop that steers the transmit group to the terminal sync
`timescale 1ns/1ns
`default_nettype none
module msc_dpll
    import msc_pkg::*;
(
    input  wire logic     i_clk,
    input  wire logic     i_resetn,
    input  wire logic     i_ce,
    input  wire logic     i_enable,
    input  wire logic     i_sync,
    input  wire msc_inc_t i_ref_acc,
    output logic          o_hold,
    output logic          o_extra,
    output logic          o_locked
);

    logic sync_d;
    logic hold;
    logic extra;
    logic locked;
    logic next_sync_d;
    logic next_hold;
    logic next_extra;
    logic next_locked;
    logic edge_seen;
    logic err_small;

    ////////////////////////////////////////////////////////////////////////////
    // On each sync rising edge, the local reference phase is the error.
    // One cycle of correction per edge keeps jitter low at the cost of slow pull-in.
    always_comb
    begin
        edge_seen   = i_sync && !sync_d;
        err_small   = (i_ref_acc < (ACC_W'(1) << DPLL_DEAD_W))
                   || (i_ref_acc > ~(ACC_W'(1) << DPLL_DEAD_W));
        next_sync_d = i_sync;
        next_hold   = 1'b0;
        next_extra  = 1'b0;
        next_locked = locked;
        if (!i_enable)
            next_locked = 1'b0;
        else if (edge_seen)
        begin
            next_locked = err_small;
            if (!err_small)
            begin
                next_hold  = !i_ref_acc[ACC_W-1];   // Reference early: wait
                next_extra = i_ref_acc[ACC_W-1];    // Reference late: catch up
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            sync_d <= 1'b0;
            hold   <= 1'b0;
            extra  <= 1'b0;
            locked <= 1'b0;
        end
        else if (i_ce)
        begin
            sync_d <= next_sync_d;
            hold   <= next_hold;
            extra  <= next_extra;
            locked <= next_locked;
        end
    end

    assign o_hold   = hold;
    assign o_extra  = extra;
    assign o_locked = locked;

endmodule
`default_nettype wire

// ---- msc_clock_modes.sv ----
// Operating-mode clock generation for the modem front end sample, bit and symbol clocks
//
// How it works
// - Extended terminal-sync mode runs like the terminal-sync mode with every clock except a 19,200 Hz bit clock at 8/7 rate.
// - Extended internal-sync mode scales every clock by 8/7 with the same limits and bit-rate option.
// - In extended modes a 19,200 Hz bit clock may be chosen and is not scaled by 8/7.
// - Async terminal-sync mode locks the transmit clocks to the sync input; receive uses its adjust only.
// - Plain async mode leaves the loop unused and adjusts transmit and receive independently.
// - The conversion strobe rate is 9.6, 8.0 or 7.2 kHz from the sample-rate field.
// - Mode codes are 000 async, 111 async sync, 100 terminal sync, 101 internal sync, 110 loopback.
// - Transmit bit and symbol rates come from the transmit fields, receive ones from the receive fields.
// - Any mix of bit, symbol and terminal-sync rates is accepted in async terminal-sync mode.
// - Receive adjust is control register 4 and transmit adjust is control register 5.
// - In loopback a receive phase change moves the transmit clocks by the same amount.
// - Bit and symbol clocks of each direction stay synchronous to that direction's strobe.
// - Entering a V.32 family mode from async or async terminal-sync mode performs a soft reset before locking; moves inside the family only realign.
`timescale 1ns/1ns
`default_nettype none
module msc_clock_modes
    import msc_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_resetn,
    input  wire logic            i_ce,
    input  wire logic [2:0]      i_operating_mode_field,
    input  wire logic            i_extended_rate,
    input  wire logic [1:0]      i_sample_rate,
    input  wire logic [2:0]      i_tx_bit_rate,
    input  wire logic [2:0]      i_tx_symbol_rate,
    input  wire logic [2:0]      i_rx_bit_rate,
    input  wire logic [2:0]      i_rx_symbol_rate,
    input  wire logic [1:0]      i_sync_rate,
    input  wire logic [PH_W-1:0] i_receive_phase_adjust,
    input  wire logic            i_receive_phase_write,
    input  wire logic [PH_W-1:0] i_tx_phase_adjust,
    input  wire logic            i_tx_phase_write,
    input  wire logic            i_terminal_sync_input,
    output logic                 o_tx_conversion_strobe,
    output logic                 o_rx_conversion_strobe,
    output logic                 o_tx_bit_clock,
    output logic                 o_rx_bit_clock,
    output logic                 o_tx_symbol_clock,
    output logic                 o_rx_symbol_clock,
    output logic [2:0]           o_active_mode,
    output logic                 o_soft_reset,
    output logic                 o_dpll_active,
    output logic                 o_tx_locked
);

    ////////////////////////////////////////////////////////////////////////////
    // Channel map: 0..2 receive conv/bit/symbol, 3..5 transmit, 6 transmit sync reference
    localparam int NCH = 7;

    logic [2:0]        mode;
    logic              ext;
    logic [7:0]        rst_cnt;
    logic              restart;
    logic [2:0]        next_mode;
    logic              next_ext;
    logic [7:0]        next_rst_cnt;
    logic              next_restart;
    logic              mode_valid;
    logic              v32_new;
    logic              v32_old;

    logic [STEP_W-1:0] step     [2];
    logic [STEP_W-1:0] next_step[2];
    logic              adj_extra[2];
    logic              adj_hold [2];

    msc_inc_t          inc      [NCH];
    logic              ch_hold  [NCH];
    logic              ch_extra [NCH];
    logic              ch_pulse [NCH];
    logic              ch_level [NCH];
    msc_inc_t          ch_acc   [NCH];

    logic              dpll_en;
    logic              dpll_hold;
    logic              dpll_extra;
    logic              tx_hold;
    logic              tx_extra;
    logic              scaled;

    ////////////////////////////////////////////////////////////////////////////
    // Mode register; soft reset and realignment on V.32 family entry
    always_comb
    begin
        mode_valid   = 1'b0;
        case (i_operating_mode_field)
            MODE_ASYNC, MODE_ASYNC_TERMINAL_SYNC_INPUT, MODE_V32_TERMINAL_SYNC_INPUT, MODE_V32_INT, MODE_V32_LOOP:
                mode_valid = 1'b1;
            default:
                mode_valid = 1'b0;
        endcase
        next_mode    = mode_valid ? i_operating_mode_field : mode;
        next_ext     = i_extended_rate;
        v32_new      = next_mode[2] && (next_mode != MODE_ASYNC_TERMINAL_SYNC_INPUT);
        v32_old      = mode[2] && (mode != MODE_ASYNC_TERMINAL_SYNC_INPUT);
        next_rst_cnt = (rst_cnt != 8'h00) ? rst_cnt - 8'h01 : 8'h00;
        next_restart = 1'b0;
        if (next_mode != mode && v32_new)
        begin
            if (!v32_old)
                next_rst_cnt = SOFT_RESET_CYC;
            else
                next_restart = 1'b1;
        end
        // Clocks realign only once the soft reset has run out
        if (rst_cnt == 8'h01)
            next_restart = 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mode    <= MODE_RESET;
            ext     <= 1'b0;
            rst_cnt <= 8'h00;
            restart <= 1'b0;
        end
        else if (i_ce)
        begin
            mode    <= next_mode;
            ext     <= next_ext;
            rst_cnt <= next_rst_cnt;
            restart <= next_restart;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rate selection; 8/7 only in the V.32 sync modes with extended rate set
    always_comb
    begin
        scaled = ext && (mode == MODE_V32_TERMINAL_SYNC_INPUT || mode == MODE_V32_INT);
        inc[0] = scaled ? CONV_INC_X[{1'b0, i_sample_rate}] : CONV_INC[{1'b0, i_sample_rate}];
        inc[3] = inc[0];
        inc[1] = (scaled && i_rx_bit_rate != BIT_SEL_FIXED) ? BIT_INC_X[i_rx_bit_rate]
                                                           : BIT_INC[i_rx_bit_rate];
        inc[4] = (scaled && i_tx_bit_rate != BIT_SEL_FIXED) ? BIT_INC_X[i_tx_bit_rate]
                                                           : BIT_INC[i_tx_bit_rate];
        inc[2] = scaled ? SYM_INC_X[i_rx_symbol_rate] : SYM_INC[i_rx_symbol_rate];
        inc[5] = scaled ? SYM_INC_X[i_tx_symbol_rate] : SYM_INC[i_tx_symbol_rate];
        // Any sync rate may pair with any bit and symbol rate
        inc[6] = scaled ? SYNC_INC_X[{1'b0, i_sync_rate}] : SYNC_INC[{1'b0, i_sync_rate}];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase adjust steppers: index 0 receive, 1 transmit.
    // Each unit becomes PH_UNIT_CYC held or advanced master cycles, so a
    // large jump takes a few thousand cycles rather than tearing the strobe.
    always_comb
    begin
        logic [PH_W-1:0] val;
        logic            wr;
        val = '0;
        wr  = 1'b0;
        for (int g = 0; g < 2; g++)
        begin
            val = (g == 0) ? i_receive_phase_adjust : i_tx_phase_adjust;
            wr  = (g == 0) ? i_receive_phase_write : i_tx_phase_write;
            if (ext && !val[PH_W-1] && val > PH_EXT_MAX)
                val = PH_EXT_MAX;
            next_step[g] = step[g];
            adj_extra[g] = 1'b0;
            adj_hold[g]  = 1'b0;
            if (wr)
                next_step[g] = STEP_W'($signed(val) * $signed(PH_UNIT_CYC));
            else if (!step[g][STEP_W-1] && step[g] != '0)
            begin
                adj_extra[g] = 1'b1;
                next_step[g] = step[g] - STEP_W'(1);
            end
            else if (step[g][STEP_W-1])
            begin
                adj_hold[g]  = 1'b1;
                next_step[g] = step[g] + STEP_W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            step[0] <= '0;
            step[1] <= '0;
        end
        else if (i_ce)
        begin
            step[0] <= next_step[0];
            step[1] <= next_step[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit steering per mode
    always_comb
    begin
        dpll_en  = (mode == MODE_ASYNC_TERMINAL_SYNC_INPUT) || (mode == MODE_V32_TERMINAL_SYNC_INPUT);
        tx_hold  = 1'b0;
        tx_extra = 1'b0;
        case (mode)
            MODE_ASYNC, MODE_V32_INT:
            begin
                tx_hold  = adj_hold[1];
                tx_extra = adj_extra[1];
            end
            MODE_ASYNC_TERMINAL_SYNC_INPUT, MODE_V32_TERMINAL_SYNC_INPUT:
            begin
                tx_hold  = dpll_hold;
                tx_extra = dpll_extra;
            end
            MODE_V32_LOOP:
            begin
                tx_hold  = adj_hold[0];
                tx_extra = adj_extra[0];
            end
            default:
            begin
                tx_hold  = 1'b0;
                tx_extra = 1'b0;
            end
        endcase
    end

    msc_dpll u_dpll
    (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_ce      (i_ce),
        .i_enable  (dpll_en),
        .i_sync    (i_terminal_sync_input),
        .i_ref_acc (ch_acc[6]),
        .o_hold    (dpll_hold),
        .o_extra   (dpll_extra),
        .o_locked  (o_tx_locked)
    );

    ////////////////////////////////////////////////////////////////////////////
    // One accumulator per clock; all channels of a direction share restart
    // and steps, so bit and symbol clocks never drift from their strobe
    genvar c;
    generate
        for (c = 0; c < NCH; c++)
        begin : g_ch
            msc_nco u_nco
            (
                .i_clk     (i_clk),
                .i_resetn  (i_resetn),
                .i_ce      (i_ce),
                .i_restart (restart),
                .i_hold    (c < 3 ? adj_hold[0] : tx_hold),
                .i_extra   (c < 3 ? adj_extra[0] : tx_extra),
                .i_inc     (inc[c]),
                .o_pulse   (ch_pulse[c]),
                .o_level   (ch_level[c]),
                .o_acc     (ch_acc[c])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs; strobes and clocks all come straight from accumulator flops
    assign o_rx_conversion_strobe = ch_pulse[0];
    assign o_rx_bit_clock         = ch_level[1];
    assign o_rx_symbol_clock      = ch_level[2];
    assign o_tx_conversion_strobe = ch_pulse[3];
    assign o_tx_bit_clock         = ch_level[4];
    assign o_tx_symbol_clock      = ch_level[5];
    assign o_active_mode          = mode;
    assign o_soft_reset           = (rst_cnt != 8'h00);
    assign o_dpll_active          = dpll_en;

endmodule
`default_nettype wire

// ---- msc_clock_modes_assertions.sv ----
// Port checker for the mode, soft reset and strobe behaviour of the clock block
`timescale 1ns/1ns
`default_nettype none
module msc_clock_modes_checker
(
    input wire logic       i_clk,
    input wire logic       i_resetn,
    input wire logic       i_ce,
    input wire logic [2:0] i_operating_mode_field,
    input wire logic [2:0] o_active_mode,
    input wire logic       o_soft_reset,
    input wire logic       o_dpll_active,
    input wire logic       o_tx_locked,
    input wire logic       o_tx_conversion_strobe,
    input wire logic       o_rx_conversion_strobe
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////
    // Mode register: valid codes land one edge later, reserved ones change nothing
    property p_take;
        i_ce && i_operating_mode_field inside {3'h0, 3'h4, 3'h5, 3'h6, 3'h7}
            |=> o_active_mode == $past(i_operating_mode_field);
    endproperty
    a_take: assert property (p_take) else $error("mode code not taken");
    property p_reserved;
        i_ce && i_operating_mode_field inside {3'h1, 3'h2, 3'h3} |=> $stable(o_active_mode);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code changed mode");
    ////////////////////////////////////////////////////////////
    // Loop use follows the mode; a disabled loop may not claim lock
    property p_dpll;
        o_dpll_active == (o_active_mode == 3'h7 || o_active_mode == 3'h4);
    endproperty
    a_dpll: assert property (p_dpll) else $error("loop enable wrong for mode");
    property p_unlock;
        i_ce && !o_dpll_active ##1 !o_dpll_active |-> !o_tx_locked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("lock shown with loop off");
    ////////////////////////////////////////////////////////////
    // Soft reset on entry to the V.32 family, then aligned strobes
    property p_sr_entry;
        i_ce && o_active_mode inside {3'h4, 3'h5, 3'h6} && $past(o_active_mode) inside {3'h0, 3'h7}
            |-> o_soft_reset;
    endproperty
    a_sr_entry: assert property (p_sr_entry) else $error("no soft reset on entry");
    property p_sr_hold;
        $rose(o_soft_reset) |-> o_soft_reset [*8];
    endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("soft reset too short");
    property p_align;
        $fell(o_soft_reset) |-> ##[1:2] (o_tx_conversion_strobe && o_rx_conversion_strobe);
    endproperty
    a_align: assert property (p_align) else $error("strobes not aligned after soft reset");
    // Strobes are single-cycle pulses; a stuck transmit strobe would trip this, a low enable legally holds it
    property p_pulse;
        o_tx_conversion_strobe && i_ce |=> !o_tx_conversion_strobe;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
    // Loopback keeps transmit on the receive strobe, adjust included
    property p_loop;
        o_active_mode == 3'h6 && $past(o_active_mode, 3) == 3'h6
            |-> o_tx_conversion_strobe == o_rx_conversion_strobe;
    endproperty
    a_loop: assert property (p_loop) else $error("loopback strobes apart");
endmodule
bind msc_clock_modes msc_clock_modes_checker u_chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_operating_mode_field(i_operating_mode_field), .o_active_mode(o_active_mode),
    .o_soft_reset(o_soft_reset), .o_dpll_active(o_dpll_active), .o_tx_locked(o_tx_locked),
    .o_tx_conversion_strobe(o_tx_conversion_strobe), .o_rx_conversion_strobe(o_rx_conversion_strobe));
`default_nettype wire

// ---- msc_sync_gen.sv ----
// Model of the external terminal sync source
`timescale 1ns/1ns
`default_nettype none
module msc_sync_gen
#(
    parameter int HALF_CYC = 13021
)
(
    input  wire logic i_clk,
    input  wire logic i_enable,
    output var logic  o_sync
);
    int cnt = 0;
    initial o_sync = 1'b0;
    // Square wave at the programmed sync rate; held low when off so no stray edge reaches the loop
    always @(negedge i_clk)
    begin
        if (!i_enable)
        begin
            cnt <= 0;
            o_sync <= 1'b0;
        end
        else if (cnt == HALF_CYC - 1)
        begin
            cnt <= 0;
            o_sync <= !o_sync;
        end
        else
            cnt <= cnt + 1;
    end
endmodule
`default_nettype wire

// ---- msc_clock_modes_tb_top.sv ----
// Self-checking bench for the modem sample clock mode logic
`timescale 1ns/1ns
`default_nettype none
module msc_clock_modes_tb_top
    import msc_pkg::*;
;
    logic        i_clk = 1'b0;
    logic        i_resetn = 1'b0;
    logic [2:0]  mode = 3'h0;
    logic        ext = 1'b0;
    logic [1:0]  srate = 2'h2;
    logic [2:0]  txb = 3'h0;
    logic [2:0]  rxb = 3'h0;
    logic [8:0]  rxv = 9'h000;
    logic [8:0]  txv = 9'h000;
    logic        rxw = 1'b0;
    logic        txw = 1'b0;
    logic        sync_en = 1'b0;
    logic        ce = 1'b1;
    logic        sync;
    logic        txc, rxc, txbc, rxbc, txsc, rxsc, srst, dpll, lock;
    logic [2:0]  amode;
    int          miscompares = 0;
    int          checks = 0;
    int          cyc = 0;
    int          last [4];
    logic [31:0] per [4];
    logic [3:0]  sp = 4'h0;
    logic [3:0]  mon;
    ////////////////////////////////////////////////////////////
    msc_clock_modes u_msc_clock_modes (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce), .i_operating_mode_field(mode),
        .i_extended_rate(ext), .i_sample_rate(srate), .i_tx_bit_rate(txb), .i_tx_symbol_rate(3'h7),
        .i_rx_bit_rate(rxb), .i_rx_symbol_rate(3'h7), .i_sync_rate(2'h2),
        .i_receive_phase_adjust(rxv), .i_receive_phase_write(rxw), .i_tx_phase_adjust(txv),
        .i_tx_phase_write(txw), .i_terminal_sync_input(sync), .o_tx_conversion_strobe(txc),
        .o_rx_conversion_strobe(rxc), .o_tx_bit_clock(txbc), .o_rx_bit_clock(rxbc),
        .o_tx_symbol_clock(txsc), .o_rx_symbol_clock(rxsc), .o_active_mode(amode),
        .o_soft_reset(srst), .o_dpll_active(dpll), .o_tx_locked(lock));
    // Sync at 9600 Hz to match the programmed sync field
    msc_sync_gen #(.HALF_CYC(13021)) u_msc_sync_gen (.i_clk(i_clk), .i_enable(sync_en), .o_sync(sync));
    initial forever #2 i_clk = ~i_clk;
    // Rising-edge interval of each watched output, in master clocks; sampled
    // on the falling edge, where the registered outputs have settled
    assign mon = {rxbc, txbc, rxc, txc};
    always @(negedge i_clk)
    begin
        cyc <= cyc + 1;
        sp <= mon;
        for (int i = 0; i < 4; i++)
            if (mon[i] && !sp[i])
            begin
                per[i] <= 32'(cyc - last[i]);
                last[i] <= cyc;
            end
    end
    ////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g, input int tol);
        checks++;
        if (^g === 1'bx || g + tol < e || g > e + tol)
        begin
            miscompares++;
            $display("[FAIL] %s expected %0d seen %0d", name, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Enter a V.32 mode from async, adjust phases, then time one period after the aligned restart
    task automatic run_case(input logic [2:0] md, input logic x, input logic [1:0] sr, input logic [2:0] tb,
                            input logic [2:0] rb, input int tv, input int rv, input real fs, input real ft,
                            input real fr);
        real k;
        int  ps;
        int  n;
        k = x ? 8.0 / 7.0 : 1.0;
        ps = int'(250.0e6 / (fs * k));
        mode = 3'h0;
        repeat (4) @(negedge i_clk);
        {ext, srate, txb, rxb, mode} = {x, sr, tb, rb, md};
        repeat (2) @(negedge i_clk);
        chk("soft reset start", 1, srst, 0);
        n = 0;
        while (srst !== 1'b0 && n < 200)
        begin
            @(negedge i_clk);
            n++;
        end
        chk("soft reset end", 0, srst, 0);
        repeat (3) @(negedge i_clk);
        chk("symbol clocks after restart", 0, {txsc, rxsc}, 0);
        {txv, rxv, txw, rxw} = {9'(tv), 9'(rv), 2'b11};
        @(negedge i_clk);
        {txw, rxw} = 2'b00;
        repeat (ps + 100) @(negedge i_clk);
        chk("tx strobe period", ps - 16 * tv, per[0], 3);
        chk("rx strobe period", ps - 16 * rv, per[1], 3);
        chk("tx bit period", int'(250.0e6 / (ft * (ft == 19200.0 ? 1.0 : k))), per[2], 3);
        chk("rx bit period", int'(250.0e6 / (fr * (fr == 19200.0 ? 1.0 : k))), per[3], 3);
        // 4800 Hz symbol clocks are past their first half period here, so both stand high
        chk("symbol clocks running", 3, {txsc, rxsc}, 0);
    endtask
    ////////////////////////////////////////////////////////////
    // Watchdog at 94k cycles, above the roughly 85k-cycle run
    initial
    begin
        #376000;
        miscompares++;
        wrap_up();
    end
    initial
    begin
        logic [2:0] codes [5];
        logic       dpl [5];
        codes = '{3'h0, 3'h7, 3'h4, 3'h5, 3'h6};
        dpl = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        repeat (8) @(negedge i_clk);
        i_resetn = 1'b1;
        sync_en = 1'b1;
        @(negedge i_clk);
        chk("mode after reset", 0, amode, 0);
        for (int i = 0; i < 5; i++)
        begin
            mode = codes[i];
            repeat (30) @(negedge i_clk);
            chk("active mode", codes[i], amode, 0);
            chk("loop active", dpl[i], dpll, 0);
        end
        for (int i = 1; i < 4; i++)
        begin
            mode = 3'(i);
            repeat (2) @(negedge i_clk);
            chk("reserved code", 6, amode, 0);
        end
        mode = 3'h0;
        repeat (3) @(negedge i_clk);
        chk("tx lock in async", 0, lock, 0);
        // A low enable must freeze the mode register
        ce = 1'b0;
        mode = 3'h7;
        repeat (3) @(negedge i_clk);
        chk("mode frozen by enable", 0, amode, 0);
        mode = 3'h0;
        ce = 1'b1;
        sync_en = 1'b0;
        run_case(3'h5, 1'b1, 2'h2, 3'h7, 3'h7, 0, 192, 9600.0, 19200.0, 19200.0);
        run_case(3'h4, 1'b1, 2'h0, 3'h6, 3'h5, 0, 0, 7200.0, 14400.0, 12000.0);
        run_case(3'h5, 1'b0, 2'h1, 3'h5, 3'h6, 10, 0, 8000.0, 12000.0, 14400.0);
        mode = 3'h6;
        repeat (2) @(negedge i_clk);
        chk("loopback mode", 6, amode, 0);
        chk("no soft reset inside V.32", 0, srst, 0);
        {rxv, rxw} = {9'h014, 1'b1};
        @(negedge i_clk);
        rxw = 1'b0;
        repeat (400) @(negedge i_clk);
        wrap_up();
    end
endmodule
`default_nettype wire
